// ---- rtl/magnetometer_spi_frame_output.sv ----
`timescale 1ns/10ps
module magnetometer_spi_frame_output
	import mag_frame_pkg::*;
#(
	parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic clk_link_i,
	input wire logic pulse_per_second_in_i,
	input wire logic external_ref_clock_i,
	input wire logic clear_to_send_i,
	input wire logic serial_rx_line_i,
	input wire startup_t startup_i,
	input wire logic mag1_valid_i,
	input wire logic mag2_valid_i,
	input wire logic [2:0] aux_id_i,
	input wire payload_t meas_i,
	input wire payload_t diag_i,
	output logic serial_clock_out_o,
	output logic frame_select_n_o,
	output logic serial_tx_line_o,
	output logic ready_to_send_o,
	output logic [7:0] rx_byte_o,
	output logic pps_present_o,
	output logic pps_locked_o,
	output logic ref_present_o
);
	function automatic logic [7:0] tx_bit_index(input logic [7:0] cnt);
		// byte order low first, bits within a byte msb first
		tx_bit_index = {cnt[7:3], ~cnt[2:0]};
	endfunction : tx_bit_index

	// ---------------- system domain ----------------
	logic pps_s1_r;
	logic pps_s2_r;
	logic pps_s3_r;
	logic ref_s1_r;
	logic ref_s2_r;
	logic ref_s3_r;
	logic [16:0] tick_cnt_r;
	logic [9:0] ms_cnt_r;
	logic [10:0] pps_age_r;
	logic pps_present_r;
	logic pps_locked_r;
	logic [7:0] ref_age_r;
	logic ref_present_r;
	logic [10:0] sample_cnt_r;
	frame_t hold_r;
	logic req_r;
	// completion toggle, driven in the link domain
	logic ack_r;
	logic ack_s1_r;
	logic ack_s2_r;

	wire pps_rise = pps_s2_r & ~pps_s3_r;
	wire [16:0] tick_last = 17'(CYCLES_PER_MS_P - 1);
	wire tick_wrap = (tick_cnt_r == tick_last);
	wire late_win = (ms_cnt_r == FRAMES_PER_PPS_LAST) &&
		(tick_cnt_r >= tick_last - 17'(PPS_TOL_CYC));
	wire early_win = (ms_cnt_r == 10'h000) && (tick_cnt_r <= 17'(PPS_TOL_CYC));
	// a pulse just after the natural tick that starts millisecond 0 realigns without a second frame
	wire tick = tick_wrap | (pps_rise & ~early_win);
	wire link_free = (req_r == ack_s2_r);
	wire load = tick & link_free;
	wire ref_rise = ref_s2_r & ~ref_s3_r;

	wire [3:0] stage_field = startup_i.done ? 4'h0 : startup_i.stage;
	wire [15:0] status_word = {pps_present_r, pps_locked_r, stage_field,
		startup_i.substage, 6'h00, startup_i.failed};
	wire [15:0] counter_word = {mag2_valid_i, mag1_valid_i, aux_id_i,
		sample_cnt_r};
	wire payload_t slots = startup_i.done ? meas_i : diag_i;
	wire frame_t next_frame = {slots, status_word, counter_word};

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pps_s1_r <= 1'b0;
			pps_s2_r <= 1'b0;
			pps_s3_r <= 1'b0;
		end else begin
			pps_s1_r <= pulse_per_second_in_i;
			pps_s2_r <= pps_s1_r;
			pps_s3_r <= pps_s2_r;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_s3_r <= 1'b0;
		end else begin
			ref_s1_r <= external_ref_clock_i;
			ref_s2_r <= ref_s1_r;
			ref_s3_r <= ref_s2_r;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
		end
	end

	// millisecond tick, realigned on each pulse
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_r <= 17'h00000;
			ms_cnt_r <= 10'h000;
		end else if (pps_rise || tick_wrap) begin
			tick_cnt_r <= 17'h00000;
			ms_cnt_r <= (pps_rise || ms_cnt_r == FRAMES_PER_PPS_LAST) ? 10'h000 : ms_cnt_r + 10'h001;
		end else begin
			tick_cnt_r <= tick_cnt_r + 17'h00001;
		end
	end

	// pulse presence and lock flags
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pps_age_r <= PPS_TIMEOUT_MS;
			pps_present_r <= 1'b0;
			pps_locked_r <= 1'b0;
		end else begin
			if (pps_rise) begin
				pps_age_r <= 11'h000;
			end else if (tick && pps_age_r != PPS_TIMEOUT_MS) begin
				pps_age_r <= pps_age_r + 11'h001;
			end
			pps_present_r <= pps_rise | (pps_age_r < PPS_TIMEOUT_MS);
			if (pps_rise) begin
				pps_locked_r <= pps_present_r & (late_win | early_win);
			end else if (pps_age_r == PPS_TIMEOUT_MS) begin
				pps_locked_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_age_r <= REF_TIMEOUT;
			ref_present_r <= 1'b0;
		end else begin
			ref_age_r <= ref_rise ? 8'h00 : (ref_age_r == REF_TIMEOUT ? ref_age_r : ref_age_r + 8'h01);
			ref_present_r <= (ref_age_r != REF_TIMEOUT);
		end
	end

	// frame capture and toggle request towards the link domain
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hold_r <= '0;
			req_r <= 1'b0;
			sample_cnt_r <= SAMPLE_CNT_RST;
		end else if (load) begin
			hold_r <= next_frame;
			req_r <= ~req_r;
			sample_cnt_r <= sample_cnt_r + 11'h001;
		end
	end

	assign pps_present_o = pps_present_r;
	assign pps_locked_o = pps_locked_r;
	assign ref_present_o = ref_present_r;

	// ---------------- link domain ----------------
	logic lrst_s1_r;
	logic lrst_s2_r;
	logic req_s1_r;
	logic req_s2_r;
	logic req_s3_r;
	logic rx_s1_r;
	logic rx_s2_r;
	frame_t shift_r;
	link_state_t lstate_r, lstate_nxt;
	logic [7:0] bit_cnt_r;
	logic phase_r;
	logic [3:0] gap_r;
	logic sclk_r;
	logic csn_r;
	logic tx_r;
	logic rts_r;
	logic [7:0] rx_sh_r;
	logic [7:0] rx_byte_r;

	wire new_req = req_s2_r ^ req_s3_r;
	wire last_bit = (bit_cnt_r == LAST_BIT);
	wire shift_step = (lstate_r == L_SHIFT) && phase_r && !last_bit;
	// the link is handed back only once the gap is over, so no request is lost in it
	wire frame_end = (lstate_r == L_GAP) && (gap_r == GAP_CYC);
	// the line synchroniser delays each bit by one bit time; the last one lands in the gap
	wire rx_take = ((lstate_r == L_SHIFT) && !phase_r && (bit_cnt_r != 8'h00)) ||
		((lstate_r == L_GAP) && (gap_r == 4'h0));
	wire rx_last = (lstate_r == L_GAP) || (bit_cnt_r[2:0] == 3'h0);
	wire [7:0] rx_next = {rx_sh_r[6:0], rx_s2_r};

	always_ff @(posedge clk_link_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lrst_s1_r <= 1'b0;
			lrst_s2_r <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_s2_r <= lrst_s1_r;
		end
	end

	always_comb begin
		lstate_nxt = lstate_r;
		case (lstate_r)
			L_IDLE: begin
				if (new_req) begin
					lstate_nxt = L_SHIFT;
				end
			end
			L_SHIFT: begin
				if (phase_r && last_bit) begin
					lstate_nxt = L_GAP;
				end
			end
			L_GAP: begin
				if (gap_r == GAP_CYC) begin
					lstate_nxt = L_IDLE;
				end
			end
			default: lstate_nxt = L_IDLE;
		endcase
	end

	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
		end else begin
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
		end
	end

	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			rx_s1_r <= 1'b0;
			rx_s2_r <= 1'b0;
		end else begin
			rx_s1_r <= serial_rx_line_i;
			rx_s2_r <= rx_s1_r;
		end
	end

	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			lstate_r <= L_IDLE;
		end else begin
			lstate_r <= lstate_nxt;
		end
	end

	// select and serial clock: the clock runs only while the frame shifts
	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			phase_r <= 1'b0;
			sclk_r <= 1'b0;
			csn_r <= 1'b1;
		end else begin
			case (lstate_r)
				L_IDLE: begin
					phase_r <= 1'b0;
					sclk_r <= 1'b0;
					csn_r <= ~new_req;
				end
				L_SHIFT: begin
					phase_r <= ~phase_r;
					sclk_r <= ~phase_r;
				end
				default: begin
					phase_r <= 1'b0;
					sclk_r <= 1'b0;
					csn_r <= 1'b1;
				end
			endcase
		end
	end

	// transmit shifter: data changes with clock low, receiver samples on the rising edge
	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			shift_r <= '0;
			bit_cnt_r <= 8'h00;
			tx_r <= 1'b0;
		end else if (lstate_r == L_IDLE) begin
			bit_cnt_r <= 8'h00;
			if (new_req) begin
				shift_r <= hold_r;
				tx_r <= hold_r[tx_bit_index(8'h00)];
			end
		end else if (shift_step) begin
			bit_cnt_r <= bit_cnt_r + 8'h01;
			tx_r <= shift_r[tx_bit_index(bit_cnt_r + 8'h01)];
		end
	end

	// gap length between frames
	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			gap_r <= 4'h0;
		end else if (lstate_r == L_GAP) begin
			gap_r <= gap_r + 4'h1;
		end else begin
			gap_r <= 4'h0;
		end
	end

	// completion toggle back to the system domain
	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			ack_r <= 1'b0;
		end else if (frame_end) begin
			ack_r <= ~ack_r;
		end
	end

	// receive monitor, msb first
	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			rx_sh_r <= 8'h00;
			rx_byte_r <= 8'h00;
		end else if (rx_take) begin
			rx_sh_r <= rx_next;
			if (rx_last) begin
				rx_byte_r <= rx_next;
			end
		end
	end

	// handshake output has no function and stays low
	always_ff @(posedge clk_link_i or negedge lrst_s2_r) begin
		if (!lrst_s2_r) begin
			rts_r <= 1'b0;
		end else begin
			rts_r <= 1'b0;
		end
	end

	assign serial_clock_out_o = sclk_r;
	assign frame_select_n_o = csn_r;
	assign serial_tx_line_o = tx_r;
	assign ready_to_send_o = rts_r;
	assign rx_byte_o = rx_byte_r;
endmodule : magnetometer_spi_frame_output

// ---- rtl/mag_frame_pkg.sv ----
// Function
// - module is serial master: drives clock, select and transmit line, receives on input line
// - one complete frame is emitted every millisecond, 1000 frames per second
// - a frame is exactly 28 bytes, fourteen 16-bit blocks
// - every 16/32-bit field goes least significant byte first; receiver reassembles likewise
// - counter word bits 10..0 count frames and wrap from 0x7ff to zero
// - counter word bits 13..11 identify the sensor occupying the auxiliary slots
// - counter bit 15 flags valid second magnetometer, bit 14 the first
// - status bit 0 is one on startup failure, zero on success
// - status bits 6..1 are reserved and carry no meaning
// - during startup status bits 13..10 give stage, bits 9..7 the sub-stage
// - after successful startup status bits 13..10 are cleared
// - during startup the data slots carry diagnostic values instead of measurements
// - status bit 15 is high while pulse-per-second pulses are being received
// - status bit 14 is high while the sample tick is locked to the pulse
// - tick locks to pulses: 1000 samples per interval within plus or minus 500 ns
// - the rising edge of the pulse-per-second input is the one acted on
// - each field slot carries a 32-bit unsigned reading, 50 fT per bit
// - each magnetometer has a 32-bit status slot after its field reading
// - four 16-bit auxiliary slots X, Y, Z, temperature, multiplexed by the id bits
// - the handshake lines have no function; the handshake input is ignored
// - optional 10 MHz reference input is accepted; operation is correct without it
package mag_frame_pkg;
	localparam int CLK_SYS_HZ = 100_000_000;
	localparam int FRAME_RATE_HZ = 1000;
	localparam int CYCLES_PER_MS = CLK_SYS_HZ / FRAME_RATE_HZ;
	localparam int PPS_TOL_NS = 500;
	localparam int PPS_TOL_CYC = PPS_TOL_NS / (1_000_000_000 / CLK_SYS_HZ);
	localparam logic [9:0] FRAMES_PER_PPS_LAST = 10'h3e7;
	localparam logic [10:0] PPS_TIMEOUT_MS = 11'h44c;
	localparam logic [10:0] SAMPLE_CNT_RST = 11'h000;
	localparam int FRAME_BYTES = 28;
	localparam int FRAME_BITS = FRAME_BYTES * 8;
	localparam logic [7:0] LAST_BIT = 8'hdf;
	localparam logic [3:0] GAP_CYC = 4'h8;
	localparam logic [7:0] REF_TIMEOUT = 8'hff;

	typedef struct packed {
		logic [15:0] aux_temp;
		logic [15:0] aux_z;
		logic [15:0] aux_y;
		logic [15:0] aux_x;
		logic [31:0] mag2_status;
		logic [31:0] mag2_field;
		logic [31:0] mag1_status;
		logic [31:0] mag1_field;
	} payload_t;

	typedef struct packed {
		logic failed;
		logic done;
		logic [3:0] stage;
		logic [2:0] substage;
	} startup_t;

	typedef struct packed {
		payload_t payload;
		logic [15:0] status;
		logic [15:0] counter;
	} frame_t;

	typedef enum logic [2:0] {
		L_IDLE = 3'b001,
		L_SHIFT = 3'b010,
		L_GAP = 3'b100
	} link_state_t;
endpackage : mag_frame_pkg

// ---- tb/mag_frame_props.sv ----
`timescale 1ns/10ps
module mag_frame_props (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic clk_link_i,
	input wire logic pulse_per_second_in_i,
	input wire logic serial_clock_out_o,
	input wire logic frame_select_n_o,
	input wire logic serial_tx_line_o,
	input wire logic ready_to_send_o,
	input wire logic pps_present_o,
	input wire logic pps_locked_o
);
	// clock-high cycles seen inside the current frame
	logic [8:0] rise_r;
	always_ff @(posedge clk_link_i or negedge resetn_i) begin
		if (!resetn_i) rise_r <= '0;
		else if (frame_select_n_o) rise_r <= '0;
		else if (serial_clock_out_o) rise_r <= rise_r + 9'h1;
	end
	a_frame_bits: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
		$rose(frame_select_n_o) |-> rise_r == 9'h0e0) else $error("frame bit count wrong");
	a_gap_len: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
		$rose(frame_select_n_o) |-> frame_select_n_o [*8]) else $error("gap too short");
	a_clk_idle: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
		frame_select_n_o |-> !serial_clock_out_o) else $error("clock outside frame");
	a_tx_hold: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
		!frame_select_n_o && serial_clock_out_o |-> $stable(serial_tx_line_o))
		else $error("data moved at clock rise");
	a_clk_pulse: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
		serial_clock_out_o |=> !serial_clock_out_o) else $error("clock high too long");
	a_frame_start: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
		$fell(frame_select_n_o) |-> !serial_clock_out_o ##1 serial_clock_out_o)
		else $error("bad frame start");
	a_rts_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!ready_to_send_o) else $error("handshake output active");
	a_lock_present: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		pps_locked_o |-> pps_present_o) else $error("locked without pulses");
	a_pps_cause: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		$rose(pps_present_o) |-> pulse_per_second_in_i && !$past(pulse_per_second_in_i, 8))
		else $error("pulse flag without rising edge");
endmodule : mag_frame_props

// ---- tb/frame_receiver.sv ----
`timescale 1ns/10ps
module frame_receiver (
	input wire logic clk_link_i,
	input wire logic sck_i,
	input wire logic sel_n_i,
	input wire logic tx_i,
	output logic rx_o,
	output logic [223:0] frame_o,
	output int frames_o
);
	localparam logic [7:0] RX_PAT = 8'h3c;
	logic [7:0] n_r;
	logic [2:0] k_r;
	logic idle_r = 1'h0;
	initial frames_o = 0;
	always @(negedge sel_n_i) begin
		n_r = 8'h0;
		k_r = 3'h0;
	end
	// bytes land in order, least significant byte first, bits msb first
	always @(posedge sck_i) if (!sel_n_i) begin
		frame_o[{n_r[7:3], ~n_r[2:0]}] <= tx_i;
		n_r <= n_r + 8'h1;
	end
	// only a frame of the full bit count is counted; the select settling after reset is not
	always @(posedge sel_n_i) if (n_r == 8'he0) frames_o <= frames_o + 1;
	always @(negedge sck_i) k_r <= k_r + 3'h1;
	always @(posedge clk_link_i) idle_r <= ~idle_r;
	// unselected line toggles so no stale value can pass
	assign rx_o = sel_n_i ? idle_r : RX_PAT[~k_r];
endmodule : frame_receiver

// ---- tb/magnetometer_spi_frame_output_test.sv ----
`timescale 1ns/10ps
module magnetometer_spi_frame_output_test;
	import mag_frame_pkg::*;
	logic clk_sys_i = 0, clk_link_i = 0, resetn_i = 0, pps = 0, ref_clk = 0, ref_on = 1;
	logic cts = 0, m1 = 0, m2 = 0, sck, sel_n, tx, rx, rts, pres, lock, refp;
	logic [2:0] aux = 0;
	logic [7:0] rxb;
	logic [223:0] got, mk;
	startup_t st = '0;
	payload_t meas = '0, diag = '0;
	int frames, miscompares = 0, check_count = 0, cycles = 0;
	time t0;
	always #5 clk_sys_i = ~clk_sys_i;
	initial #3.3 forever #7.5 clk_link_i = ~clk_link_i;
	always #50 if (ref_on) ref_clk = ~ref_clk;
	magnetometer_spi_frame_output #(.CYCLES_PER_MS_P(800)) magnetometer_spi_frame_output_inst (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_link_i(clk_link_i),
		.pulse_per_second_in_i(pps), .external_ref_clock_i(ref_clk), .clear_to_send_i(cts),
		.serial_rx_line_i(rx), .startup_i(st), .mag1_valid_i(m1), .mag2_valid_i(m2),
		.aux_id_i(aux), .meas_i(meas), .diag_i(diag), .serial_clock_out_o(sck),
		.frame_select_n_o(sel_n), .serial_tx_line_o(tx), .ready_to_send_o(rts),
		.rx_byte_o(rxb), .pps_present_o(pres), .pps_locked_o(lock), .ref_present_o(refp));
	frame_receiver frame_receiver_inst (.clk_link_i(clk_link_i), .sck_i(sck), .sel_n_i(sel_n),
		.tx_i(tx), .rx_o(rx), .frame_o(got), .frames_o(frames));
	task automatic check(input logic [223:0] seen, input logic [223:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	function automatic frame_t expect_frame(input int n, input logic p);
		expect_frame.counter = {m2, m1, aux, n[10:0]};
		expect_frame.status = {p, 1'h0, st.done ? 4'h0 : st.stage, st.substage, 6'h00, st.failed};
		expect_frame.payload = st.done ? meas : diag;
	endfunction : expect_frame
	// new inputs between frames, well before the next tick samples them
	task automatic stir(input int i);
		@(posedge clk_sys_i);
		#1;
		{m1, m2, cts} = 3'($urandom);
		aux = 3'($urandom);
		meas = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		diag = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		st = startup_t'(9'($urandom));
		st.done = 1'(i > 2);
		st.stage = (i == 0) ? 4'hb : 4'($urandom_range(11, 1));
	endtask : stir
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(38));
		stir(0);
		repeat (11) @(posedge clk_sys_i);
		#1 resetn_i = 1;
		for (int i = 0; i < 12; i++) begin
			t0 = $time;
			for (int w = 0; w < 2000 && frames == i; w++) @(posedge clk_sys_i);
			// lock flags of the pulse-started frame race the pulse itself
			mk = (i == 7) ? ~(224'h3 << 30) : '1;
			check(got & mk, expect_frame(i, 1'(i > 7)) & mk);
			// each frame but 0, 7 and 8 ends one tick period, 800 system clocks, after the wait starts, within 40 ns
			if (i > 0 && i != 7 && i != 8) check($time - t0 > 7960 && $time - t0 < 8040, 1);
			if (i == 1) check(rxb, 8'h3c);
			if (i == 3) check(refp, 1);
			if (i == 3) ref_on = 0;
			if (i == 5) check(refp, 0);
			if (i == 8) check({pres, lock}, 2'h2);
			stir(i + 1);
			if (i == 6) begin
				// pulse after the link is handed back, so it starts a frame of its own
				repeat (40) @(posedge clk_sys_i);
				#1 pps = 1;
				repeat (20) @(posedge clk_sys_i);
				#1 pps = 0;
			end
		end
		complete_run();
	end
endmodule : magnetometer_spi_frame_output_test
bind magnetometer_spi_frame_output mag_frame_props mag_frame_props_inst (
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_link_i(clk_link_i),
	.pulse_per_second_in_i(pulse_per_second_in_i), .serial_clock_out_o(serial_clock_out_o),
	.frame_select_n_o(frame_select_n_o), .serial_tx_line_o(serial_tx_line_o),
	.ready_to_send_o(ready_to_send_o), .pps_present_o(pps_present_o),
	.pps_locked_o(pps_locked_o));
